// [hw/power_sleep_sequencer.sv]
// Power and sleep sequencer with Avalon-MM register access
//
// Chosen here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/10ps
`include "pss_defines.svh"

//////////////////////////////////////////////////////////////////////////////
module power_sleep_sequencer (
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  pss_pkg::avmm_req_s       avmm_req,
   output pss_pkg::avmm_rsp_s       avmm_rsp,
   input  wire logic                dsp_boot_select_pin,
   output pss_pkg::mod_ctrl_s       mods,
   output logic                     dsp_core_reset_n,
   output logic                     dsp_isolate,
   output logic                     dsp_domain_on,
   output logic                     ext_power_irq
);

   localparam int N = `PSS_NUM_MODULES;

   pss_pkg::state_s   s;
   pss_pkg::state_s   next_s;
   pss_pkg::mod_ctrl_s decoded;

   //////////////////////////////////////////////////////////////////////////
   // Module state decode

   module_state_decode #(
      .N         (N),
      .DSP_FIRST (`PSS_DSP_FIRST)
   ) u_decode (
      .cur    (s.mod_cur),
      .dsp_on (s.dsp_on),
      .ctrl   (decoded)
   );

   //////////////////////////////////////////////////////////////////////////
   // Next state

   logic                          req;
   logic                          take;
   logic                          wr;
   logic [`PSS_DATA_W-1:0]        wd;
   logic                          mod_hit;
   logic [`PSS_IDX_W-1:0]         idx;
   logic [`PSS_DATA_W-1:0]        rd;
   logic                          cmd_wr;
   logic                          dom1_wr;
   logic                          epc_wr;
   logic                          confirm_on;
   logic                          confirm_off;

   always_comb begin
      req     = avmm_req.read | avmm_req.write;
      // Request completes on the edge where waitrequest is seen low
      take    = req & ~s.rsp.waitrequest;
      wr      = take & avmm_req.write;
      wd      = avmm_req.writedata;
      idx     = avmm_req.address[`PSS_IDX_W+1:2];
      mod_hit = (avmm_req.address[`PSS_ADDR_W-1:`PSS_ADDR_W-2] == `PSS_MOD_PAGE)
                && (idx < `PSS_IDX_W'(N));

      // Named strobes keep the sequencer arms short
      cmd_wr      = wr && (avmm_req.address == `PSS_OFS_CMD);
      dom1_wr     = wr && (avmm_req.address == `PSS_OFS_DOM1);
      epc_wr      = wr && (avmm_req.address == `PSS_OFS_EPC);
      confirm_on  = dom1_wr && wd[`PSS_BIT_GOOD];
      confirm_off = dom1_wr && !wd[`PSS_BIT_GOOD];
      next_s  = s;

      ///////////////////////////////////////////////////////////////////////
      // Read mux; unmapped addresses read zero
      rd = '0;
      if (mod_hit) begin
         rd[`PSS_MOD_NEXT_LSB+:2] = s.mod_next[idx];
         rd[`PSS_MOD_CUR_LSB+:2]  = s.mod_cur[idx];
         rd[`PSS_BIT_EMU_IE]      = s.lreset_emul_irq_enable[idx];
         if (idx == `PSS_IDX_W'(`PSS_DSP_MODULE)) begin
            rd[`PSS_BIT_LRST] = s.lrst_bit;
         end
      end else begin
         unique case (avmm_req.address)
            `PSS_OFS_STAT: begin
               rd[`PSS_BIT_GO0] = (s.seq0 != pss_pkg::SEQ_IDLE);
               rd[`PSS_BIT_GO1] = (s.seq1 != pss_pkg::SEQ_IDLE);
            end
            `PSS_OFS_DOM0: begin
               rd[`PSS_BIT_NEXT]   = 1'b1;
               rd[`PSS_BIT_DSTATE] = 1'b1;
            end
            `PSS_OFS_DOM1: begin
               rd[`PSS_BIT_NEXT]   = s.dsp_next;
               rd[`PSS_BIT_GOOD]   = s.power_good_confirm;
               rd[`PSS_BIT_DSTATE] = s.dsp_on;
            end
            `PSS_OFS_EPC: begin
               rd[`PSS_BIT_EPC]    = s.ext_power_pending;
               rd[`PSS_BIT_EPC_IE] = s.pending_irq_en;
            end
            default: rd = '0;
         endcase
      end

      // Single-cycle answer, waitrequest back high straight after
      next_s.rsp.waitrequest = ~(req & s.rsp.waitrequest);
      if (req & s.rsp.waitrequest) begin
         next_s.rsp.readdata = rd;
      end

      ///////////////////////////////////////////////////////////////////////
      // Register writes
      if (wr && mod_hit) begin
         next_s.mod_next[idx]               = wd[`PSS_MOD_NEXT_LSB+:2];
         next_s.lreset_emul_irq_enable[idx] = wd[`PSS_BIT_EMU_IE];
         if (idx == `PSS_IDX_W'(`PSS_DSP_MODULE)) begin
            next_s.lrst_bit = wd[`PSS_BIT_LRST];
         end
      end
      if (dom1_wr) begin
         next_s.dsp_next           = wd[`PSS_BIT_NEXT];
         next_s.power_good_confirm = wd[`PSS_BIT_GOOD];
      end
      if (epc_wr) begin
         next_s.pending_irq_en = wd[`PSS_BIT_EPC_IE];
      end

      ///////////////////////////////////////////////////////////////////////
      // Permanent domain: module changes only, power never touched
      unique case (s.seq0)
         pss_pkg::SEQ_IDLE: begin
            if (cmd_wr && wd[`PSS_BIT_GO0]) begin
               next_s.seq0 = pss_pkg::SEQ_APPLY;
            end
         end
         pss_pkg::SEQ_APPLY: begin
            for (int i = 0; i < `PSS_DSP_FIRST; i++) begin
               next_s.mod_cur[i] = s.mod_next[i];
            end
            next_s.seq0 = pss_pkg::SEQ_SETTLE;
         end
         pss_pkg::SEQ_SETTLE: begin
            // Controls are registered from mod_cur one edge later
            next_s.seq0 = pss_pkg::SEQ_IDLE;
         end
         default: next_s.seq0 = pss_pkg::SEQ_IDLE;
      endcase

      ///////////////////////////////////////////////////////////////////////
      // DSP domain sequence
      unique case (s.seq1)
         pss_pkg::SEQ_IDLE: begin
            if (cmd_wr && wd[`PSS_BIT_GO1]) begin
               if (s.dsp_next && !s.dsp_on) begin
                  next_s.seq1 = pss_pkg::SEQ_PEND_ON;
               end else if (!s.dsp_next && s.dsp_on) begin
                  next_s.seq1 = pss_pkg::SEQ_APPLY;
               end else begin
                  next_s.seq1 = pss_pkg::SEQ_APPLY;
               end
            end
         end
         pss_pkg::SEQ_PEND_ON: begin
            next_s.ext_power_pending = 1'b1;
            // Only a matching confirmation resumes; else wait forever
            if (confirm_on) begin
               next_s.ext_power_pending = 1'b0;
               next_s.dsp_on            = 1'b1;
               next_s.seq1              = pss_pkg::SEQ_ISO_OFF;
            end
         end
         pss_pkg::SEQ_ISO_OFF: begin
            next_s.dsp_isolate = 1'b0;
            next_s.seq1        = pss_pkg::SEQ_APPLY;
         end
         pss_pkg::SEQ_APPLY: begin
            if (s.dsp_on) begin
               for (int i = `PSS_DSP_FIRST; i < N; i++) begin
                  next_s.mod_cur[i] = s.mod_next[i];
               end
            end
            // Power-off isolates before the rail may drop
            if (s.dsp_on && !s.dsp_next) begin
               next_s.seq1 = pss_pkg::SEQ_ISO_ON;
            end else begin
               next_s.seq1 = pss_pkg::SEQ_SETTLE;
            end
         end
         pss_pkg::SEQ_ISO_ON: begin
            next_s.dsp_isolate = 1'b1;
            next_s.seq1        = pss_pkg::SEQ_PEND_OFF;
         end
         pss_pkg::SEQ_PEND_OFF: begin
            next_s.ext_power_pending = 1'b1;
            if (confirm_off) begin
               next_s.ext_power_pending = 1'b0;
               next_s.dsp_on            = 1'b0;
               // Removed power drops the current state of every DSP module to RESET_CLOCK_OFF
               for (int i = `PSS_DSP_FIRST; i < N; i++) begin
                  next_s.mod_cur[i] = pss_pkg::RESET_CLOCK_OFF;
               end
               next_s.seq1 = pss_pkg::SEQ_SETTLE;
            end
         end
         pss_pkg::SEQ_SETTLE: begin
            next_s.seq1 = pss_pkg::SEQ_IDLE;
         end
         default: next_s.seq1 = pss_pkg::SEQ_IDLE;
      endcase

      ///////////////////////////////////////////////////////////////////////
      // Registered outputs
      next_s.mods          = decoded;
      next_s.ext_power_irq = s.ext_power_pending & s.pending_irq_en;
      // Core held whenever module reset is active; memories untouched
      next_s.dsp_core_reset_n = decoded.reset_n[`PSS_DSP_MODULE]
                                & s.lrst_bit;

      ///////////////////////////////////////////////////////////////////////
      // Synchronous reset; boot pin picks DSP defaults
      if (!rst_n) begin
         next_s                    = '0;
         next_s.rsp.waitrequest    = 1'b1;
         next_s.seq0               = pss_pkg::SEQ_IDLE;
         next_s.seq1               = pss_pkg::SEQ_IDLE;
         for (int i = 0; i < N; i++) begin
            next_s.mod_next[i] = `PSS_MOD_DEFAULT;
            next_s.mod_cur[i]  = `PSS_MOD_DEFAULT;
         end
         next_s.dsp_on      = dsp_boot_select_pin;
         next_s.dsp_next    = dsp_boot_select_pin;
         next_s.dsp_isolate = ~dsp_boot_select_pin;
         next_s.lrst_bit    = dsp_boot_select_pin;
         if (dsp_boot_select_pin) begin
            next_s.mod_next[`PSS_DSP_MODULE] = pss_pkg::ENABLED;
            next_s.mod_cur[`PSS_DSP_MODULE]  = pss_pkg::ENABLED;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clk) begin
      s <= next_s;
   end

   //////////////////////////////////////////////////////////////////////////
   // Outputs straight from the state flops

   assign avmm_rsp         = s.rsp;
   assign mods             = s.mods;
   assign dsp_core_reset_n = s.dsp_core_reset_n;
   assign dsp_isolate      = s.dsp_isolate;
   assign dsp_domain_on    = s.dsp_on;
   assign ext_power_irq    = s.ext_power_irq;

endmodule

// [include/pss_defines.svh]
// Constants for the power and sleep sequencer
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH

`define PSS_NUM_MODULES   41
`define PSS_DSP_MODULE    39
`define PSS_DSP_FIRST     39
`define PSS_ADDR_W        10
`define PSS_DATA_W        32
`define PSS_IDX_W         6

// Register byte addresses
`define PSS_OFS_CMD       10'h000
`define PSS_OFS_STAT      10'h004
`define PSS_OFS_DOM0      10'h008
`define PSS_OFS_DOM1      10'h00C
`define PSS_OFS_EPC       10'h010
`define PSS_MOD_PAGE      2'h1

// Field positions
`define PSS_BIT_GO0       0
`define PSS_BIT_GO1       1
`define PSS_BIT_NEXT      0
`define PSS_BIT_GOOD      1
`define PSS_BIT_DSTATE    8
`define PSS_BIT_EPC       0
`define PSS_BIT_EPC_IE    1
`define PSS_MOD_NEXT_LSB  0
`define PSS_MOD_CUR_LSB   4
`define PSS_BIT_LRST      8
`define PSS_BIT_EMU_IE    9

// Reset values
`define PSS_MOD_DEFAULT   2'h1

`endif

// [include/pss_pkg.sv]
// Types shared by the power and sleep sequencer files
`include "pss_defines.svh"

package pss_pkg;

   typedef enum logic [1:0] {
      RESET_CLOCK_OFF = 2'h0,
      RESET_CLOCK_ON  = 2'h1,
      CLOCK_GATED     = 2'h2,
      ENABLED         = 2'h3
   } mod_state_e;

   typedef enum logic [2:0] {
      SEQ_IDLE     = 3'h0,
      SEQ_APPLY    = 3'h1,
      SEQ_SETTLE   = 3'h2,
      SEQ_PEND_ON  = 3'h3,
      SEQ_ISO_OFF  = 3'h4,
      SEQ_ISO_ON   = 3'h5,
      SEQ_PEND_OFF = 3'h6
   } seq_e;

   typedef struct packed {
      logic [`PSS_ADDR_W-1:0] address;
      logic                   read;
      logic                   write;
      logic [`PSS_DATA_W-1:0] writedata;
   } avmm_req_s;

   typedef struct packed {
      logic [`PSS_DATA_W-1:0] readdata;
      logic                   waitrequest;
   } avmm_rsp_s;

   typedef struct packed {
      logic [`PSS_NUM_MODULES-1:0] reset_n;
      logic [`PSS_NUM_MODULES-1:0] clk_en;
   } mod_ctrl_s;

   typedef struct packed {
      avmm_rsp_s                         rsp;
      seq_e                              seq0;
      seq_e                              seq1;
      logic                              dsp_next;
      logic                              power_good_confirm;
      logic                              dsp_on;
      logic                              dsp_isolate;
      logic                              ext_power_pending;
      logic                              pending_irq_en;
      logic                              ext_power_irq;
      logic                              lrst_bit;
      logic                              dsp_core_reset_n;
      logic [`PSS_NUM_MODULES-1:0][1:0]  mod_next;
      logic [`PSS_NUM_MODULES-1:0][1:0]  mod_cur;
      logic [`PSS_NUM_MODULES-1:0]       lreset_emul_irq_enable;
      mod_ctrl_s                         mods;
   } state_s;

endpackage

// [hw/module_state_decode.sv]
// Decode of module states into module reset and clock controls
`timescale 1ns/10ps
`include "pss_defines.svh"

module module_state_decode #(
   parameter int N         = `PSS_NUM_MODULES,
   parameter int DSP_FIRST = `PSS_DSP_FIRST
) (
   input  wire logic [N-1:0][1:0] cur,
   input  wire logic              dsp_on,
   output pss_pkg::mod_ctrl_s     ctrl
);

   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_mod
         // Unpowered modules sit in reset with no clock
         localparam bit IN_DSP = (i >= DSP_FIRST);
         assign ctrl.reset_n[i] = cur[i][1] & (dsp_on | ~IN_DSP);
         assign ctrl.clk_en[i]  = cur[i][0] & (dsp_on | ~IN_DSP);
      end
   endgenerate

endmodule

// [test/pss_assertions.sv]
// Port checker for the power and sleep sequencer
`timescale 1ns/10ps
module pss_checker (
   input wire logic          clk,
   input wire logic          rst_n,
   input pss_pkg::avmm_req_s avmm_req,
   input pss_pkg::avmm_rsp_s avmm_rsp,
   input wire logic          dsp_boot_select_pin,
   input pss_pkg::mod_ctrl_s mods,
   input wire logic          dsp_core_reset_n,
   input wire logic          dsp_isolate,
   input wire logic          dsp_domain_on,
   input wire logic          ext_power_irq
);
   logic req;
   assign req = avmm_req.read | avmm_req.write;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   //////////////////////////////////////////////////////////////////////////////
   AST_ANSWER_NEXT: assert property (req && avmm_rsp.waitrequest |=> !avmm_rsp.waitrequest)
      else $error("no answer one cycle after request");
   AST_ANSWER_ONE: assert property (!avmm_rsp.waitrequest |=> avmm_rsp.waitrequest)
      else $error("answer held too long");
   AST_QUIET_BUS: assert property (!req |=> avmm_rsp.waitrequest)
      else $error("answer without request");
   AST_ISO_WHILE_OFF: assert property (!dsp_domain_on |-> dsp_isolate)
      else $error("isolation off while domain unpowered");
   AST_ISO_OFF_ON: assert property ($rose(dsp_domain_on) |-> ##[0:4] !dsp_isolate)
      else $error("isolation kept after power on");
   AST_OFF_MODS: assert property ((!dsp_domain_on)[*3] |->
      mods.reset_n[40:39] == 2'h0 && mods.clk_en[40:39] == 2'h0)
      else $error("dsp modules alive in unpowered domain");
   // Module transitions may also move the core reset, so allow a few edges
   AST_CORE_FROM_WRITE: assert property ($changed(dsp_core_reset_n) && $past(rst_n, 2) |->
      $past(avmm_req.write) || $past(avmm_req.write, 2) || $past(avmm_req.write, 3)
      || $past(avmm_req.write, 4))
      else $error("core reset moved without software");
   AST_DOMAIN_FROM_WRITE: assert property ($changed(dsp_domain_on) |->
      $past(avmm_req.write) || $past(avmm_req.write, 2))
      else $error("domain power changed without confirm");
   AST_IRQ_HOLDS: assert property (ext_power_irq && !avmm_req.write
      && !$past(avmm_req.write) && !$past(avmm_req.write, 2) |=> ext_power_irq)
      else $error("pending irq dropped without confirm");
   cover property ($rose(ext_power_irq));
   cover property ($fell(dsp_domain_on));
   cover property ($rose(dsp_core_reset_n));
endmodule

bind power_sleep_sequencer pss_checker pss_checker_i (
   .clk(clk), .rst_n(rst_n), .avmm_req(avmm_req), .avmm_rsp(avmm_rsp),
   .dsp_boot_select_pin(dsp_boot_select_pin), .mods(mods),
   .dsp_core_reset_n(dsp_core_reset_n), .dsp_isolate(dsp_isolate),
   .dsp_domain_on(dsp_domain_on), .ext_power_irq(ext_power_irq)
);

// [test/supply_model.sv]
// External supply that powers the DSP domain
`timescale 1ns/10ps
module supply_model #(
   parameter int RAMP = 6
) (
   input  wire logic clk,
   input  wire logic apply,
   output logic      rail_on
);
   // Rail lags the request, so software must wait before confirming
   int count = 0;
   initial rail_on = 1'b0;
   always @(posedge clk) begin
      if (apply == rail_on) begin
         count <= 0;
      end else if (count == RAMP - 1) begin
         rail_on <= apply;
         count <= 0;
      end else begin
         count <= count + 1;
      end
   end
endmodule

// [test/tb.sv]
// Self-checking bench for the power and sleep sequencer
`timescale 1ns/10ps
module tb;
   logic               clk;
   logic               rst_n;
   logic               pin;
   logic               apply;
   logic               rail_on;
   logic               core_n;
   logic               iso;
   logic               dom_on;
   logic               irq;
   pss_pkg::avmm_req_s req;
   pss_pkg::avmm_rsp_s rsp;
   pss_pkg::mod_ctrl_s mods;
   int                 fails = 0;
   int                 checks = 0;
   power_sleep_sequencer power_sleep_sequencer_i (
      .clk(clk), .rst_n(rst_n), .avmm_req(req), .avmm_rsp(rsp),
      .dsp_boot_select_pin(pin), .mods(mods), .dsp_core_reset_n(core_n),
      .dsp_isolate(iso), .dsp_domain_on(dom_on), .ext_power_irq(irq));
   supply_model supply_model_i (.clk(clk), .apply(apply), .rail_on(rail_on));
   //////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Holds the request until the edge that samples waitrequest low
   task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      req <= '{a, !wr, wr, d};
      do begin
         @(posedge clk);
         n++;
      end while (rsp.waitrequest !== 1'b0 && n < 20);
      q = rsp.readdata;
      req <= '0;
      if (n >= 20) fails++;
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [9:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0, q);
   endtask
   task automatic poll(input logic [9:0] a, input int b, input logic v);
      logic [31:0] q;
      int n;
      n = 0;
      do begin
         rd(a, q);
         n++;
      end while (q[b] !== v && n < 50);
      check("poll", 32'(q[b]), 32'(v));
   endtask
   task automatic supply(input logic v);
      int n;
      n = 0;
      apply <= v;
      @(posedge clk);
      while (rail_on !== v && n < 50) begin
         @(posedge clk);
         n++;
      end
      check("rail", 32'(rail_on), 32'(v));
   endtask
   //////////////////////////////////////////////////////////////////////////////
   task automatic t_perm;
      logic [31:0] q;
      check("boot", {29'h0, iso, dom_on, core_n}, 32'h4);
      for (int i = 0; i < 4; i++) begin
         wr(10'h100 + 10'(4 * i), 32'(i));
      end
      wr(10'h000, 32'h1);
      poll(10'h004, 0, 1'b0);
      for (int i = 0; i < 4; i++) begin
         rd(10'h100 + 10'(4 * i), q);
         check("state", 32'(q[5:4]), 32'(i));
         check("pins", 32'({mods.reset_n[i], mods.clk_en[i]}), 32'(i));
      end
      check("others", 32'({mods.reset_n[20:5], mods.clk_en[20:5]}), 32'h0000FFFF);
      wr(10'h008, 32'h0);
      rd(10'h008, q);
      check("perm", q, 32'h101);
      rd(10'h3FC, q);
      check("hole", q, 32'h0);
   endtask
   task automatic t_power(input logic on);
      logic [31:0] q;
      wr(10'h010, 32'h2);
      wr(10'h1A0, 32'h201);
      wr(10'h00C, {30'h0, !on, on});
      wr(10'h000, 32'h2);
      poll(10'h010, 0, 1'b1);
      repeat (30) @(posedge clk);
      rd(10'h004, q);
      check("held", {29'h0, q[1], irq, iso}, 32'h7);
      check("before", 32'(dom_on), 32'(!on));
      supply(on);
      wr(10'h00C, {30'h0, on, on});
      poll(10'h004, 1, 1'b0);
      check("after", {29'h0, dom_on, iso, irq}, {29'h0, on, !on, 1'b0});
      rd(10'h00C, q);
      check("dom", 32'(q[8]), 32'(on));
      rd(10'h19C, q);
      check("cur", 32'(q[5:4]), 32'(on));
   endtask
   task automatic t_local;
      logic [31:0] q;
      wr(10'h19C, 32'h3);
      wr(10'h000, 32'h2);
      poll(10'h004, 1, 1'b0);
      check("run", {29'h0, mods.reset_n[39], mods.clk_en[39], core_n}, 32'h6);
      wr(10'h19C, 32'h103);
      repeat (2) @(posedge clk);
      check("go", {29'h0, mods.reset_n[40], mods.clk_en[40], core_n}, 32'h3);
      check("mod", 32'(mods.reset_n[39]), 32'h1);
      rd(10'h1A0, q);
      check("emul", 32'(q[9]), 32'h1);
      wr(10'h19C, 32'h101);
      wr(10'h000, 32'h2);
      poll(10'h004, 1, 1'b0);
      check("over", 32'({mods.reset_n[39], core_n}), 32'h0);
   endtask
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      rst_n = 1'b0;
      req = '0;
      pin = 1'b0;
      apply = 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_perm;
      t_power(1'b1);
      t_local;
      t_power(1'b0);
      check("off", 32'({mods.reset_n[40:39], mods.clk_en[40:39]}), 32'h0);
      rst_n <= 1'b0;
      pin <= 1'b1;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(negedge clk);
      check("boot", {28'h0, dom_on, iso, core_n, mods.reset_n[39]}, 32'hB);
      give_verdict;
   end
   // Whole run needs well under two thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      give_verdict;
   end
endmodule
